// ===== hdl/idu_cfg.svh
`ifndef IDU_CFG_SVH
`define IDU_CFG_SVH

// Word width and instruction fields
`define IDU_WORD_W      32
`define IDU_CNT_W       5
`define IDU_CNT_LAST    5'h1F
`define IDU_OPC_HI      31
`define IDU_OPC_LO      26
`define IDU_DVD_HI      25
`define IDU_DVD_LO      21
`define IDU_DVS_HI      20
`define IDU_DVS_LO      16
`define IDU_ZERO_HI     15
`define IDU_ZERO_LO     6
`define IDU_FUN_HI      5
`define IDU_FUN_LO      0

// Encodings
`define IDU_OPC_SPECIAL 6'h00
`define IDU_FUN_SDIV    6'h1A
`define IDU_FUN_UDIV    6'h1B
`define IDU_ZERO_FIELD  10'h000

`endif

// ===== hdl/idu_pkg.sv
package idu_pkg;
   `include "idu_cfg.svh"

   typedef logic [`IDU_WORD_W-1:0] idu_word_t;
   typedef logic [4:0]             idu_sel_t;

   typedef enum logic [1:0]
   {
      IDU_IDLE,
      IDU_RUN,
      IDU_FIX
   } idu_state_t;
endpackage

// ===== hdl/idu_divide_unit.sv
// Overview of operation
// - Signed divide: quotient and remainder registers
// - Decode signed divide opcode, function, zero field
// - Unsigned divide on zero-extended operands
// - Decode unsigned divide, same fields, zeros
// - No arithmetic exception ever raised
// - Zero divisor leaves results undefined
// - Stall result reads while divide busy
// - Divide runs beside the pipeline
// - Read right before divide stays correct
`timescale 1ns/10ps
`include "idu_cfg.svh"

module idu_divide_unit
(
   // Clock and reset
   input  wire logic              clock_in,
   input  wire logic              rst_n_in,
   // Instruction decode
   input  wire logic [31:0]       instr_in,
   // Start request from the issue stage
   input  wire logic              start_in,
   input  wire logic              signed_in,
   input  wire idu_pkg::idu_word_t dividend_in,
   input  wire idu_pkg::idu_word_t divisor_in,
   // Result read request
   input  wire logic              read_req_in,
   // Decode answers
   output logic                   is_divide_out,
   output logic                   is_signed_out,
   output idu_pkg::idu_sel_t      dividend_select_out,
   output idu_pkg::idu_sel_t      divisor_select_out,
   // Status and results
   output logic                   busy_out,
   output logic                   stall_out,
   output logic                   done_out,
   output logic                   exception_out,
   output idu_pkg::idu_word_t     quotient_reg_out,
   output idu_pkg::idu_word_t     remainder_reg_out
);
   import idu_pkg::*;

   // Two's-complement magnitude, used for operands and results
   function automatic idu_word_t mag(input idu_word_t v, input logic neg);
      mag = neg ? idu_word_t'(~v + 1'h1) : v;
   endfunction

   //------------------------------------------------------------
   // Decoder
   //------------------------------------------------------------
   logic      next_is_divide;
   logic      next_is_signed;
   idu_sel_t  next_dividend_select;
   idu_sel_t  next_divisor_select;
   logic      is_special;
   logic      zero_ok;

   // Registered decode so the outputs come from flops
   always_comb
   begin
      is_special     = instr_in[`IDU_OPC_HI:`IDU_OPC_LO] == `IDU_OPC_SPECIAL;
      zero_ok        = instr_in[`IDU_ZERO_HI:`IDU_ZERO_LO] == `IDU_ZERO_FIELD;
      next_is_signed = is_special && zero_ok
                       && instr_in[`IDU_FUN_HI:`IDU_FUN_LO] == `IDU_FUN_SDIV;
      next_is_divide = next_is_signed || (is_special && zero_ok
                       && instr_in[`IDU_FUN_HI:`IDU_FUN_LO] == `IDU_FUN_UDIV);
      // Selectors are passed on for every word; only a divide gives them meaning
      next_dividend_select = instr_in[`IDU_DVD_HI:`IDU_DVD_LO];
      next_divisor_select  = instr_in[`IDU_DVS_HI:`IDU_DVS_LO];
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         is_divide_out       <= 1'h0;
         is_signed_out       <= 1'h0;
         dividend_select_out <= '0;
         divisor_select_out  <= '0;
      end
      else
      begin
         is_divide_out       <= next_is_divide;
         is_signed_out       <= next_is_signed;
         dividend_select_out <= next_dividend_select;
         divisor_select_out  <= next_divisor_select;
      end
   end

   //------------------------------------------------------------
   // Restoring divider, one quotient bit per cycle
   //------------------------------------------------------------
   idu_state_t          state, next_state;
   idu_word_t           quo, next_quo;
   idu_word_t           rem, next_rem;
   idu_word_t           dvs, next_dvs;
   logic [`IDU_CNT_W-1:0] cnt, next_cnt;
   logic                neg_q, next_neg_q;
   logic                neg_r, next_neg_r;
   logic                next_done;
   logic [`IDU_WORD_W:0] trial;
   idu_word_t           shifted;

   // Operands held privately, so the pipeline may move on
   always_comb
   begin
      next_state = state;
      next_quo   = quo;
      next_rem   = rem;
      next_dvs   = dvs;
      next_cnt   = cnt;
      next_neg_q = neg_q;
      next_neg_r = neg_r;
      next_done  = 1'h0;
      shifted    = {rem[`IDU_WORD_W-2:0], quo[`IDU_WORD_W-1]};
      trial      = {1'b0, shifted} - {1'b0, dvs};
      case (state)
         IDU_IDLE:
         begin
            if (start_in)
            begin
               // Signed works on magnitudes; unsigned is zero-extended
               next_quo   = mag(dividend_in, signed_in && dividend_in[`IDU_WORD_W-1]);
               next_dvs   = mag(divisor_in, signed_in && divisor_in[`IDU_WORD_W-1]);
               next_rem   = '0;
               next_neg_q = signed_in && (dividend_in[`IDU_WORD_W-1] ^ divisor_in[`IDU_WORD_W-1]);
               next_neg_r = signed_in && dividend_in[`IDU_WORD_W-1];
               next_cnt   = '0;
               next_state = IDU_RUN;
            end
         end
         IDU_RUN:
         begin
            // Zero divisor just runs through; result is undefined
            if (!trial[`IDU_WORD_W])
            begin
               next_rem = trial[`IDU_WORD_W-1:0];
               next_quo = {quo[`IDU_WORD_W-2:0], 1'h1};
            end
            else
            begin
               next_rem = shifted;
               next_quo = {quo[`IDU_WORD_W-2:0], 1'h0};
            end
            next_cnt = cnt + 1'h1;
            if (cnt == `IDU_CNT_LAST)
               next_state = IDU_FIX;
         end
         IDU_FIX:
         begin
            // Truncation toward zero; remainder follows dividend
            next_quo   = mag(quo, neg_q);
            next_rem   = mag(rem, neg_r);
            next_done  = 1'h1;
            next_state = IDU_IDLE;
         end
         default:
            next_state = IDU_IDLE;
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         state <= IDU_IDLE;
         quo   <= '0;
         rem   <= '0;
         dvs   <= '0;
         cnt   <= '0;
         neg_q <= 1'h0;
         neg_r <= 1'h0;
      end
      else
      begin
         state <= next_state;
         quo   <= next_quo;
         rem   <= next_rem;
         dvs   <= next_dvs;
         cnt   <= next_cnt;
         neg_q <= next_neg_q;
         neg_r <= next_neg_r;
      end
   end

   //------------------------------------------------------------
   // Architectural result registers and interlock
   //------------------------------------------------------------
   logic      next_busy;
   logic      next_stall;
   logic      next_exception;
   idu_word_t next_quotient_reg;
   idu_word_t next_remainder_reg;

   // Results stay put until done, so a read just before start sees old values
   always_comb
   begin
      next_busy          = (next_state != IDU_IDLE);
      // Stall is a flop, so the issue side must keep its read raised until it drops
      next_stall         = read_req_in && next_busy;
      next_exception     = 1'h0; // Never signals overflow or zero divide
      next_quotient_reg  = next_done ? next_quo : quotient_reg_out;
      next_remainder_reg = next_done ? next_rem : remainder_reg_out;
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         quotient_reg_out  <= '0;
         remainder_reg_out <= '0;
         done_out          <= 1'h0;
         busy_out          <= 1'h0;
         stall_out         <= 1'h0;
         exception_out     <= 1'h0;
      end
      else
      begin
         quotient_reg_out  <= next_quotient_reg;
         remainder_reg_out <= next_remainder_reg;
         done_out          <= next_done;
         busy_out          <= next_busy;
         stall_out         <= next_stall;
         exception_out     <= next_exception;
      end
   end

endmodule

// ===== dv/idu_divide_unit_checker.sv
`timescale 1ns/10ps
module idu_divide_unit_checker
(
   // Clock, reset and requests
   input logic               clock_in,
   input logic               rst_n_in,
   input logic [31:0]        instr_in,
   input logic               start_in,
   input logic               read_req_in,
   // Answers
   input logic               is_divide_out,
   input logic               busy_out,
   input logic               stall_out,
   input logic               done_out,
   input logic               exception_out,
   input idu_pkg::idu_word_t quotient_reg_out,
   input idu_pkg::idu_word_t remainder_reg_out
);
   import idu_pkg::*;
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   logic [31:0] prev_instr;
   // Copy of last cycle's word, so the decode check needs no past of an expression
   always_ff @(posedge clock_in)
   begin
      prev_instr <= instr_in;
   end
   // Reset guards keep $past from seeing reset-time inputs
   chk_no_exc: assert property (exception_out == 1'h0)
      else $error("exception raised");
   chk_decode_op: assert property ($past(rst_n_in) |-> is_divide_out ==
      (prev_instr[31:26] == 6'h00 && prev_instr[15:6] == 10'h000 && prev_instr[5:1] == 5'h0D))
      else $error("decode wrong");
   chk_stall_read: assert property ($past(rst_n_in) |->
      stall_out == ($past(read_req_in) && busy_out)) else $error("stall wrong");
   chk_done_time: assert property (start_in && !busy_out |-> ##34 done_out)
      else $error("done late or early");
   chk_busy_span: assert property (start_in && !busy_out |=> busy_out[*8] ##25 busy_out)
      else $error("busy dropped");
   chk_done_pulse: assert property (done_out |=> !done_out)
      else $error("done too long");
   chk_done_idle: assert property (done_out |-> !busy_out && $past(busy_out))
      else $error("done without busy end");
   chk_quot_write: assert property ($changed(quotient_reg_out) |-> done_out)
      else $error("quotient changed without done");
   chk_rem_write: assert property ($changed(remainder_reg_out) |-> done_out)
      else $error("remainder changed without done");
endmodule
bind idu_divide_unit idu_divide_unit_checker chk_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
   .instr_in(instr_in), .start_in(start_in), .read_req_in(read_req_in),
   .is_divide_out(is_divide_out), .busy_out(busy_out), .stall_out(stall_out),
   .done_out(done_out), .exception_out(exception_out), .quotient_reg_out(quotient_reg_out),
   .remainder_reg_out(remainder_reg_out));

// ===== dv/idu_issue_model.sv
`timescale 1ns/10ps
module idu_issue_model
(
   // Clock, reset and issue command
   input  logic               clock_in,
   input  logic               rst_n_in,
   input  logic               go_in,
   input  logic               sgn_in,
   input  idu_pkg::idu_word_t a_in,
   input  idu_pkg::idu_word_t b_in,
   input  logic               busy_in,
   // Start request to the divider
   output logic               start_out,
   output logic               signed_out,
   output idu_pkg::idu_word_t dividend_out,
   output idu_pkg::idu_word_t divisor_out
);
   import idu_pkg::*;
   // One-cycle start only when idle; operands scrambled whenever go_in is low
   // Operands go through unchecked; a zero or larger divisor is issued as given
   always_ff @(posedge clock_in)
   begin
      start_out    <= rst_n_in && go_in && !busy_in && !start_out;
      signed_out   <= sgn_in;
      dividend_out <= go_in ? a_in : ~dividend_out;
      divisor_out  <= go_in ? b_in : ~divisor_out;
   end
endmodule

// ===== dv/idu_divide_unit_tb_top.sv
`timescale 1ns/10ps
module idu_divide_unit_tb_top;
   import idu_pkg::*;
   logic clock_in = 1'h0, rst_n_in = 1'h0, go = 1'h0, sgn = 1'h0, read_req_in = 1'h0;
   logic [31:0] instr_in = 32'h0;
   logic start_in, signed_in, is_divide_out, is_signed_out, busy_out, stall_out, done_out;
   logic exception_out;
   idu_word_t a = 32'h0, b = 32'h0, dividend_in, divisor_in, quotient_reg_out, remainder_reg_out;
   idu_sel_t dividend_select_out, divisor_select_out;
   int n_mismatch = 0, tests_run = 0;
   always #20 clock_in = ~clock_in;
   idu_issue_model pipe_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .go_in(go), .sgn_in(sgn),
      .a_in(a), .b_in(b), .busy_in(busy_out), .start_out(start_in), .signed_out(signed_in),
      .dividend_out(dividend_in), .divisor_out(divisor_in));
   idu_divide_unit dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
      .start_in(start_in), .signed_in(signed_in), .dividend_in(dividend_in),
      .divisor_in(divisor_in), .read_req_in(read_req_in), .is_divide_out(is_divide_out),
      .is_signed_out(is_signed_out), .dividend_select_out(dividend_select_out),
      .divisor_select_out(divisor_select_out), .busy_out(busy_out), .stall_out(stall_out),
      .done_out(done_out), .exception_out(exception_out), .quotient_reg_out(quotient_reg_out),
      .remainder_reg_out(remainder_reg_out));
   // Compare tasks and closing report
   task automatic chk_word(idu_word_t got, idu_word_t exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(logic got, logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic complete_run;
      $display("Compared %0d, mismatched %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Decode table: two divides, then bad zero field, bad function, bad opcode
   task automatic t_decode;
      logic [31:0] tbl [5] = '{32'h03A4001A, 32'h0085001B, 32'h0085005B, 32'h00850019,
                               32'h0485001A};
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clock_in);
         instr_in <= tbl[i];
         @(posedge clock_in);
         #1;
         chk_bit(is_divide_out, i < 2);
         chk_bit(is_signed_out, i == 0);
         if (i == 0) chk_word({22'h0, dividend_select_out, divisor_select_out}, 32'h3A4);
      end
   endtask
   // Result read raised the cycle before start and held, so it must stall
   task automatic t_divide(logic s, idu_word_t x, idu_word_t y, idu_word_t q, idu_word_t r,
                           logic par);
      int n;
      logic seen;
      logic held;
      idu_word_t old_q;
      old_q = quotient_reg_out;
      @(posedge clock_in);
      go <= 1'h1;
      sgn <= s;
      a <= x;
      b <= y;
      read_req_in <= 1'h1;
      @(posedge clock_in);
      go <= 1'h0;
      seen = 1'h0;
      held = 1'h1;
      if (par) t_decode;
      for (n = 0; n < 100 && done_out !== 1'h1; n++)
      begin
         @(posedge clock_in);
         #1;
         seen = seen | (stall_out === 1'h1);
         held = held & (done_out === 1'h1 || quotient_reg_out === old_q);
      end
      if (n == 100)
      begin
         n_mismatch++;
         $display("MISMATCH %0t divide never finished", $time);
      end
      else
      begin
         chk_word(quotient_reg_out, q);
         chk_word(remainder_reg_out, r);
         chk_bit(seen, 1'h1);
         chk_bit(held, 1'h1);
      end
      @(posedge clock_in);
      read_req_in <= 1'h0;
   endtask
   // Reset in the middle of a divide clears results and leaves the unit idle
   task automatic t_reset;
      @(posedge clock_in);
      go <= 1'h1;
      sgn <= 1'h0;
      a <= 32'h64;
      b <= 32'h7;
      @(posedge clock_in);
      go <= 1'h0;
      repeat (9) @(posedge clock_in);
      #1;
      chk_bit(busy_out, 1'h1);
      @(posedge clock_in);
      rst_n_in <= 1'h0;
      repeat (2) @(posedge clock_in);
      #1;
      chk_bit(busy_out, 1'h0);
      chk_bit(done_out, 1'h0);
      chk_word(quotient_reg_out, 32'h0);
      chk_word(remainder_reg_out, 32'h0);
      @(posedge clock_in);
      rst_n_in <= 1'h1;
   endtask
   initial
   begin
      repeat (16) @(posedge clock_in);
      rst_n_in <= 1'h1;
      t_divide(1'h1, 32'h7, 32'h2, 32'h3, 32'h1, 1'h1);
      t_divide(1'h1, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD, 32'hFFFFFFFF, 1'h0);
      t_divide(1'h1, 32'h7, 32'hFFFFFFFE, 32'hFFFFFFFD, 32'h1, 1'h0);
      t_divide(1'h1, 32'h80000000, 32'hFFFFFFFF, 32'h80000000, 32'h0, 1'h0);
      t_divide(1'h0, 32'hFFFFFFF9, 32'h2, 32'h7FFFFFFC, 32'h1, 1'h0);
      t_divide(1'h0, 32'hFFFFFFFF, 32'h10, 32'h0FFFFFFF, 32'hF, 1'h1);
      t_reset;
      t_divide(1'h0, 32'hFFFFFFFF, 32'h80000001, 32'h1, 32'h7FFFFFFE, 1'h0);
      complete_run;
   end
endmodule
